/* File: verilog/spps_pkg.sv */
`default_nettype none
// ------------------------------------------------------------
// Shared constants and carriers of the setpoint sequencer
// ------------------------------------------------------------
package spps_pkg;
	// Value width of MV, setpoints and program elements
	localparam int VW = 16;
	typedef logic signed [VW-1:0] spps_val_t;
	// Clock rate and one-second time base
	localparam int MCLK_HZ       = 50_000_000;
	localparam int TICK_PERIOD_S = 1;
	localparam int TICK_CYCLES   = MCLK_HZ * TICK_PERIOD_S;
	localparam int TICK_W        = 26;
	// Seconds per ramp rate unit (rate is per minute)
	localparam logic [7:0] RAMP_UNIT_S = 8'h3c;
	// Program shape
	localparam int NUM_ELEM = 8;
	localparam int NUM_PAT  = 4;
	localparam int STEP_W   = 4;
	localparam int PAT_W    = 2;
	localparam int IDX_W    = 3;
	// Repetition count ceiling and default
	localparam logic [VW-1:0] EXEC_MAX = 16'h270f;
	localparam logic [VW-1:0] EXEC_DEF = 16'h0000;
	// Element select codes on the parameter write port
	localparam logic [1:0] SEL_TARGET = 2'h0;
	localparam logic [1:0] SEL_RATE   = 2'h1;
	localparam logic [1:0] SEL_SOAK   = 2'h2;
	localparam logic [1:0] SEL_EXEC   = 2'h3;
	// Loop operating conditions that steer the MV limiters
	typedef struct packed {
		logic onoff;
		logic manual;
		logic stopped;
		logic error;
		logic auto_tuning;
		logic pos_prop;
	} spps_mode_t;
	// MV limiter settings
	typedef struct packed {
		spps_val_t       upper;
		spps_val_t       lower;
		logic [VW-1:0]   rate;
	} spps_mvcfg_t;
	// Program parameter write
	typedef struct packed {
		logic            we;
		logic [PAT_W-1:0] pat;
		logic [IDX_W-1:0] idx;
		logic [1:0]      sel;
		logic [VW-1:0]   data;
	} spps_parw_t;
	// Sequencer states
	typedef enum logic [0:0] {ST_IDLE, ST_RUN} spps_state_t;
endpackage : spps_pkg
`default_nettype wire

/* File: verilog/spps_top.sv */
`default_nettype none
// Overview of operation
// RULE_01 - Clamp output MV to upper/lower limits
// RULE_02 - Cooling negative; upper heats, lower cools
// RULE_03 - Slew MV by rate limit each second
// RULE_04 - Bypass limiters per control condition
// RULE_05 - Clamp setpoint; force stored value into limits
// RULE_06 - Range change resets setpoint limits to scale
// RULE_07 - Rate-of-rise form only when mode selected
// RULE_08 - Element i gives ramp 2i, soak 2i+1
// RULE_09 - Even count ends soak, odd ends ramp
// RULE_10 - Zero rise rate skips ramp step
// RULE_11 - Start loads setpoint with process value
// RULE_12 - Ramp moves setpoint by rate, ends at target
// RULE_13 - Changed rate or target applies at once
// RULE_14 - Soak holds setpoint for soak time
// RULE_15 - Start under input error at step 1
// RULE_16 - Hold pauses timing, lights indicator, freezes setpoint
// RULE_17 - Hold cancelled by off, run, reset, advance end
// RULE_18 - Advance moves one step, self clears
// RULE_19 - Advance under hold keeps hold
// RULE_20 - Repeat pattern by its count; zero never runs
// RULE_21 - Report repetition number; zero when stopped
// RULE_22 - Run-all walks patterns, skipping zero counts
// RULE_23 - Continue-at-power-on resumes retained pattern
// RULE_24 - Reset in run-all returns to step 0
// RULE_25 - All timing from one-second tick
module spps_top #(
	parameter int TICK_CYCLES = spps_pkg::TICK_CYCLES
) (
	input  wire logic                         mclk,
	input  wire logic                         rstn,
	input  wire spps_pkg::spps_mode_t         mode,
	input  wire spps_pkg::spps_mvcfg_t        mv_cfg,
	input  wire spps_pkg::spps_val_t          mv_calc,
	input  wire logic                         lim_we,
	input  wire spps_pkg::spps_val_t          sp_upper,
	input  wire spps_pkg::spps_val_t          sp_lower,
	input  wire logic                         range_change,
	input  wire spps_pkg::spps_val_t          scale_hi,
	input  wire spps_pkg::spps_val_t          scale_lo,
	input  wire logic                         sp_we,
	input  wire spps_pkg::spps_val_t          sp_wdata,
	input  wire spps_pkg::spps_parw_t         par_w,
	input  wire logic                         rate_mode,
	input  wire logic [spps_pkg::STEP_W-1:0]  step_count,
	input  wire spps_pkg::spps_val_t          process_value,
	input  wire logic                         input_error,
	input  wire logic                         run_cmd,
	input  wire logic                         reset_cmd,
	input  wire logic                         hold_set,
	input  wire logic                         advance_set,
	input  wire logic                         run_all_en,
	input  wire logic                         power_continue,
	input  wire logic                         restore_cmd,
	input  wire logic [spps_pkg::PAT_W-1:0]   restore_pat,
	output spps_pkg::spps_val_t               manipulated_variable,
	output spps_pkg::spps_val_t               present_setpoint,
	output spps_pkg::spps_val_t               sp_hi_out,
	output spps_pkg::spps_val_t               sp_lo_out,
	output logic [spps_pkg::STEP_W-1:0]       step_no,
	output logic [spps_pkg::PAT_W-1:0]        pattern_no,
	output logic [spps_pkg::VW-1:0]           repeat_no,
	output logic                              hold_led,
	output logic                              advance_clear,
	output logic                              running,
	output logic                              prog_end
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Clamp a value into [lo, hi]; lo wins if limits cross
	function automatic spps_pkg::spps_val_t clampv(input spps_pkg::spps_val_t v,
		input spps_pkg::spps_val_t lo, input spps_pkg::spps_val_t hi);
		clampv = (v > hi) ? hi : v;
		if (clampv < lo)
			clampv = lo;
	endfunction : clampv
	// Step from cur toward goal by at most d
	function automatic spps_pkg::spps_val_t slew(input spps_pkg::spps_val_t cur,
		input spps_pkg::spps_val_t goal, input logic [spps_pkg::VW-1:0] d);
		logic signed [spps_pkg::VW:0] up;
		logic signed [spps_pkg::VW:0] dn;
		up = 17'(cur) + $signed({1'b0, d});
		dn = 17'(cur) - $signed({1'b0, d});
		if (goal > cur)
			slew = (17'(goal) < up) ? goal : up[spps_pkg::VW-1:0];
		else
			slew = (17'(goal) > dn) ? goal : dn[spps_pkg::VW-1:0];
	endfunction : slew

	// ------------------------------------------------------------
	// One-second time base
	// ------------------------------------------------------------
	logic [spps_pkg::TICK_W-1:0] tick_cnt_reg;   // Cycle counter
	logic [spps_pkg::TICK_W-1:0] tick_cnt_next;
	logic                        tick_reg;       // One-cycle second pulse
	logic                        tick_next;
	// RULE_25 one tick source
	always_comb
	begin
		tick_next     = 1'b0;
		tick_cnt_next = tick_cnt_reg + 1'b1;
		if (tick_cnt_reg == spps_pkg::TICK_W'(TICK_CYCLES - 1))
		begin
			tick_cnt_next = '0;
			tick_next     = 1'b1;
		end
	end
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
		begin
			tick_cnt_reg <= '0;
			tick_reg     <= 1'b0;
		end
		else
		begin
			tick_cnt_reg <= tick_cnt_next;
			tick_reg     <= tick_next;
		end

	// ------------------------------------------------------------
	// Manipulated variable limiter
	// ------------------------------------------------------------
	spps_pkg::spps_val_t mv_reg;     // Output MV
	spps_pkg::spps_val_t mv_next;
	logic                byp_all;    // Both limiters off
	logic                byp_rate;   // Slew limiter off
	logic                byp_val;    // Value limiter off
	spps_pkg::spps_val_t mv_goal;    // Value-limited target
	// RULE_04 bypass conditions
	always_comb
	begin
		byp_all  = mode.onoff | mode.manual | mode.stopped | mode.error;
		byp_rate = byp_all | mode.auto_tuning;
		byp_val  = byp_all | mode.pos_prop;
	end
	// Limits act on signed MV, so cooling demand sits below zero
	always_comb
	begin
		// RULE_01 RULE_02 signed value clamp
		mv_goal = byp_val ? mv_calc : clampv(mv_calc, mv_cfg.lower, mv_cfg.upper);
		mv_next = mv_reg;
		if (byp_rate)
			mv_next = mv_goal;
		// RULE_03 per-second slew
		else if (tick_reg)
			mv_next = slew(mv_reg, mv_goal, mv_cfg.rate);
	end
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
			mv_reg <= '0;
		else
			mv_reg <= mv_next;

	// ------------------------------------------------------------
	// Setpoint limiter
	// ------------------------------------------------------------
	spps_pkg::spps_val_t sp_hi_reg;   // Active upper limit
	spps_pkg::spps_val_t sp_hi_next;
	spps_pkg::spps_val_t sp_lo_reg;   // Active lower limit
	spps_pkg::spps_val_t sp_lo_next;
	spps_pkg::spps_val_t sp_set_reg;  // Stored local setpoint
	spps_pkg::spps_val_t sp_set_next;
	always_comb
	begin
		sp_hi_next = sp_hi_reg;
		sp_lo_next = sp_lo_reg;
		// RULE_06 scale reset of limits
		if (range_change)
		begin
			sp_hi_next = scale_hi;
			sp_lo_next = scale_lo;
		end
		else if (lim_we)
		begin
			sp_hi_next = sp_upper;
			sp_lo_next = sp_lower;
		end
		// RULE_05 writes and stored value kept in range
		sp_set_next = clampv(sp_we ? sp_wdata : sp_set_reg, sp_lo_reg, sp_hi_reg);
	end
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
		begin
			sp_hi_reg  <= '0;
			sp_lo_reg  <= '0;
			sp_set_reg <= '0;
		end
		else
		begin
			sp_hi_reg  <= sp_hi_next;
			sp_lo_reg  <= sp_lo_next;
			sp_set_reg <= sp_set_next;
		end

	// ------------------------------------------------------------
	// Program element storage
	// ------------------------------------------------------------
	spps_pkg::spps_val_t target_mem [spps_pkg::NUM_PAT][spps_pkg::NUM_ELEM];
	logic [spps_pkg::VW-1:0] rate_mem [spps_pkg::NUM_PAT][spps_pkg::NUM_ELEM];
	logic [spps_pkg::VW-1:0] soak_mem [spps_pkg::NUM_PAT][spps_pkg::NUM_ELEM];
	logic [spps_pkg::VW-1:0] exec_mem [spps_pkg::NUM_PAT];
	// Counts above the ceiling are held at the ceiling
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
		begin
			for (int p = 0; p < spps_pkg::NUM_PAT; p++)
				exec_mem[p] <= spps_pkg::EXEC_DEF;
		end
		else if (par_w.we)
		begin
			case (par_w.sel)
				spps_pkg::SEL_TARGET: target_mem[par_w.pat][par_w.idx] <= par_w.data;
				spps_pkg::SEL_RATE:   rate_mem[par_w.pat][par_w.idx] <= par_w.data;
				spps_pkg::SEL_SOAK:   soak_mem[par_w.pat][par_w.idx] <= par_w.data;
				default:
					exec_mem[par_w.pat] <= (par_w.data > spps_pkg::EXEC_MAX) ?
						spps_pkg::EXEC_MAX : par_w.data;
			endcase
		end

	// ------------------------------------------------------------
	// Program sequencer
	// ------------------------------------------------------------
	spps_pkg::spps_state_t      st_reg;      // Idle or running
	spps_pkg::spps_state_t      st_next;
	logic [spps_pkg::STEP_W-1:0] step_reg;   // Current step
	logic [spps_pkg::STEP_W-1:0] step_next;
	logic [spps_pkg::PAT_W-1:0]  pat_reg;    // Current pattern, survives stop
	logic [spps_pkg::PAT_W-1:0]  pat_next;
	logic [spps_pkg::VW-1:0]     rep_reg;    // Repetition number
	logic [spps_pkg::VW-1:0]     rep_next;
	spps_pkg::spps_val_t         psp_reg;    // Program setpoint
	spps_pkg::spps_val_t         psp_next;
	logic [spps_pkg::VW-1:0]     secs_reg;   // Seconds into step
	logic [spps_pkg::VW-1:0]     secs_next;
	logic [7:0]                  unit_reg;   // Seconds into ramp unit
	logic [7:0]                  unit_next;
	logic                        hold_reg;   // Hold active
	logic                        hold_next;
	logic                        hprev_reg;  // Last hold setting
	logic                        adv_reg;    // Advance clear pulse
	logic                        end_reg;    // End pulse
	logic                        end_next;
	logic [spps_pkg::IDX_W-1:0]  ei;         // Element index of step
	logic                        step_done;  // Current step finished
	logic                        nxt_ok;     // A next pattern exists
	logic [spps_pkg::PAT_W-1:0]  nxt_pat;    // Next runnable pattern

	// Next pattern with nonzero count after the current one
	always_comb
	begin
		nxt_ok  = 1'b0;
		nxt_pat = pat_reg;
		// RULE_22 skip zero-count patterns
		for (int p = spps_pkg::NUM_PAT - 1; p >= 0; p--)
			if (p > int'(pat_reg) && exec_mem[p] != '0)
			begin
				nxt_ok  = 1'b1;
				nxt_pat = spps_pkg::PAT_W'(p);
			end
	end

	always_comb
	begin
		st_next   = st_reg;
		step_next = step_reg;
		pat_next  = pat_reg;
		rep_next  = rep_reg;
		psp_next  = psp_reg;
		secs_next = secs_reg;
		unit_next = unit_reg;
		hold_next = hold_reg;
		end_next  = 1'b0;
		step_done = 1'b0;
		// RULE_08 step 2i/2i+1 share element i
		ei = rate_mode ? step_reg[spps_pkg::STEP_W-1:1] : step_reg[spps_pkg::IDX_W-1:0];
		// RULE_16 hold follows setting edges
		if (hold_set && !hprev_reg)
			hold_next = 1'b1;
		// RULE_17 cancel on setting off
		else if (!hold_set && hprev_reg)
			hold_next = 1'b0;
		if (reset_cmd)
		begin
			// RULE_24 back to step 0, same pattern
			st_next   = spps_pkg::ST_IDLE;
			step_next = '0;
			rep_next  = '0;
			hold_next = 1'b0;
		end
		else if (run_cmd || (restore_cmd && power_continue && run_all_en))
		begin
			// RULE_23 resume retained pattern
			if (restore_cmd && !run_cmd)
				pat_next = restore_pat;
			// RULE_20 zero count never starts
			if (exec_mem[pat_next] != '0)
			begin
				st_next = spps_pkg::ST_RUN;
				// RULE_15 input error in rate mode starts at step 1
				step_next = (rate_mode && input_error) ? 1'b1 : '0;
				rep_next  = 16'h0001;
				// RULE_11 start from process value
				psp_next  = process_value;
				secs_next = '0;
				unit_next = '0;
				hold_next = 1'b0;
			end
		end
		else if (st_reg == spps_pkg::ST_RUN)
		begin
			// RULE_18 advance exactly one step
			if (advance_set)
				step_done = 1'b1;
			// RULE_09 end after last step
			else if (step_reg >= step_count)
				step_done = 1'b0;
			// RULE_10 zero rate skips the ramp
			else if (rate_mode && !step_reg[0] && rate_mem[pat_reg][ei] == '0)
				step_done = 1'b1;
			else if (rate_mode && !step_reg[0])
			begin
				// RULE_12 RULE_13 live rate and target
				if (psp_reg == target_mem[pat_reg][ei])
					step_done = 1'b1;
				else if (tick_reg && !hold_reg)
				begin
					unit_next = unit_reg + 1'b1;
					if (unit_next == spps_pkg::RAMP_UNIT_S)
					begin
						unit_next = '0;
						psp_next  = slew(psp_reg, target_mem[pat_reg][ei],
							rate_mem[pat_reg][ei]);
					end
				end
			end
			else
			begin
				// RULE_14 RULE_07 hold setpoint for soak or step time
				if (!rate_mode)
					psp_next = target_mem[pat_reg][ei];
				if (secs_reg >= soak_mem[pat_reg][ei])
					step_done = 1'b1;
				else if (tick_reg && !hold_reg)
					secs_next = secs_reg + 1'b1;
			end
			if (step_done)
			begin
				step_next = step_reg + 1'b1;
				secs_next = '0;
				unit_next = '0;
			end
			// RULE_09 pattern end once count reached
			if (step_reg >= step_count)
			begin
				step_next = '0;
				if (rep_reg < exec_mem[pat_reg])
					rep_next = rep_reg + 1'b1;
				else if (run_all_en && nxt_ok)
				begin
					pat_next = nxt_pat;
					rep_next = 16'h0001;
				end
				else
				begin
					st_next  = spps_pkg::ST_IDLE;
					rep_next = '0;
					end_next = 1'b1;
					// RULE_17 end through advance cancels hold
					hold_next = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
		begin
			st_reg    <= spps_pkg::ST_IDLE;
			step_reg  <= '0;
			pat_reg   <= '0;
			rep_reg   <= '0;
			psp_reg   <= '0;
			secs_reg  <= '0;
			unit_reg  <= '0;
			hold_reg  <= 1'b0;
			hprev_reg <= 1'b0;
			adv_reg   <= 1'b0;
			end_reg   <= 1'b0;
		end
		else
		begin
			st_reg    <= st_next;
			step_reg  <= step_next;
			pat_reg   <= pat_next;
			rep_reg   <= rep_next;
			psp_reg   <= psp_next;
			secs_reg  <= secs_next;
			unit_reg  <= unit_next;
			// RULE_19 advance leaves hold untouched
			hold_reg  <= hold_next;
			hprev_reg <= hold_set;
			// RULE_18 advance setting self clears
			adv_reg   <= advance_set;
			end_reg   <= end_next;
		end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	spps_pkg::spps_val_t out_sp_reg;  // Limited setpoint to the loop
	always_ff @(posedge mclk or negedge rstn)
		if (!rstn)
			out_sp_reg <= '0;
		// RULE_05 setpoint to loop stays in limits
		else
			out_sp_reg <= clampv((st_reg == spps_pkg::ST_RUN) ? psp_reg : sp_set_reg,
				sp_lo_reg, sp_hi_reg);

	assign manipulated_variable = mv_reg;
	assign present_setpoint     = out_sp_reg;
	assign sp_hi_out            = sp_hi_reg;
	assign sp_lo_out            = sp_lo_reg;
	assign step_no              = step_reg;
	assign pattern_no           = pat_reg;
	// RULE_21 zero while stopped
	assign repeat_no            = rep_reg;
	assign hold_led             = hold_reg;
	assign advance_clear        = adv_reg;
	assign running              = (st_reg == spps_pkg::ST_RUN);
	assign prog_end             = end_reg;
endmodule : spps_top
`default_nettype wire

/* File: tb/spps_checker.sv */
`default_nettype none
// ------------------------------------------------------------
// Port checks of the setpoint sequencer
// ------------------------------------------------------------
module spps_checker (
	input wire logic                  mclk,
	input wire logic                  rstn,
	input wire spps_pkg::spps_mode_t  mode,
	input wire spps_pkg::spps_mvcfg_t mv_cfg,
	input wire spps_pkg::spps_val_t   mv_calc,
	input wire logic                  range_change,
	input wire spps_pkg::spps_val_t   scale_hi,
	input wire spps_pkg::spps_val_t   scale_lo,
	input wire logic                  rate_mode,
	input wire spps_pkg::spps_val_t   process_value,
	input wire logic                  input_error,
	input wire logic                  run_cmd,
	input wire logic                  reset_cmd,
	input wire logic                  hold_set,
	input wire logic                  advance_set,
	input wire spps_pkg::spps_val_t   manipulated_variable,
	input wire spps_pkg::spps_val_t   present_setpoint,
	input wire spps_pkg::spps_val_t   sp_hi_out,
	input wire spps_pkg::spps_val_t   sp_lo_out,
	input wire logic [3:0]            step_no,
	input wire logic [15:0]           repeat_no,
	input wire logic                  hold_led,
	input wire logic                  advance_clear,
	input wire logic                  running
);
	logic                full_byp; // Any condition that bypasses both limiters
	spps_pkg::spps_val_t lim_val;  // Computed MV after the value limiter alone
	// Own clamp reference, so a shared slip cannot hide itself
	always_comb
	begin
		full_byp = mode.onoff | mode.manual | mode.stopped | mode.error;
		lim_val  = mv_calc;
		if (mv_calc > mv_cfg.upper)
			lim_val = mv_cfg.upper;
		else if (mv_calc < mv_cfg.lower)
			lim_val = mv_cfg.lower;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Accepted start of a program from idle
	sequence s_start;
		run_cmd && !reset_cmd && !running && rate_mode && !input_error ##1 running;
	endsequence
	a_mv_clamp: assert property (
		!full_byp && !mode.pos_prop && mode.auto_tuning |=> manipulated_variable == $past(lim_val))
		else $error("output not clamped to limits");
	a_mv_bypass: assert property (
		full_byp |=> manipulated_variable == $past(mv_calc))
		else $error("limiters not bypassed");
	a_mv_slew: assert property (
		!full_byp && !mode.auto_tuning && $stable(mv_cfg) |=>
		(int'(manipulated_variable) - int'($past(manipulated_variable)) <= int'($past(mv_cfg.rate)))
		&& (int'($past(manipulated_variable)) - int'(manipulated_variable) <= int'($past(mv_cfg.rate))))
		else $error("output moved faster than rate limit");
	a_range_reset: assert property (
		range_change && scale_lo <= scale_hi |=> sp_hi_out == $past(scale_hi) && sp_lo_out == $past(scale_lo))
		else $error("limits not reset to scale");
	a_run_start: assert property (
		s_start |-> (step_no == 4'h0 && repeat_no == 16'h0001) ##1 present_setpoint == $past(process_value, 2))
		else $error("start not loaded from process value");
	a_hold_light: assert property (
		$rose(hold_set) && running && !reset_cmd && !run_cmd |=> hold_led)
		else $error("hold indicator not lit");
	a_hold_cancel: assert property (
		$fell(hold_set) || reset_cmd |=> !hold_led)
		else $error("hold not cancelled");
	a_adv_clear: assert property (
		advance_set && running |=> advance_clear)
		else $error("advance not cleared");
	a_idle_repeat: assert property (
		!running && $past(!running) |-> repeat_no == 16'h0000)
		else $error("repetition number not zero in idle");
endmodule : spps_checker
`default_nettype wire

/* File: tb/spps_host.sv */
`default_nettype none
// ------------------------------------------------------------
// Operator side: program element writes
// ------------------------------------------------------------
module spps_host (
	input  wire logic           mclk,
	output var spps_pkg::spps_parw_t par_w
);
	// Write strobe idle from time zero
	initial par_w = '0;
	// One element write, strobe held across exactly one sampling edge
	task automatic write_elem(input logic [1:0] pat, input logic [2:0] idx,
		input logic [1:0] sel, input logic [15:0] data);
		// index and count kept in range
		par_w = '{1'h1, pat, idx, sel, (data > spps_pkg::EXEC_MAX) ? spps_pkg::EXEC_MAX : data};
		@(posedge mclk);
		#1;
		par_w.we = 1'h0;
		// Let one edge pass so back-to-back writes never reassign the strobe at once
		@(posedge mclk);
		#1;
	endtask : write_elem
endmodule : spps_host
`default_nettype wire

/* File: tb/test_setpoint_program_sequencer.sv */
`default_nettype none
// ------------------------------------------------------------
// Self-checking bench of the setpoint sequencer
// ------------------------------------------------------------
module test_setpoint_program_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TCK = 2; // Short second: one ramp unit is 120 cycles
	logic                  mclk, rstn, hold_led, advance_clear, running, prog_end;
	logic                  lim_we = 1'h0, range_change = 1'h0, sp_we = 1'h0, run_cmd = 1'h0;
	logic                  reset_cmd = 1'h0, hold_set = 1'h0, advance_set = 1'h0;
	logic                  rate_mode = 1'h1, input_error = 1'h0;
	logic                  run_all_en = 1'h0, power_continue = 1'h0, restore_cmd = 1'h0; // Tied
	logic [1:0]            restore_pat = 2'h0, pattern_no;
	logic [3:0]            step_count = 4'h2, step_no;
	logic [15:0]           repeat_no;
	spps_pkg::spps_mode_t  mode = '0;
	spps_pkg::spps_mvcfg_t mv_cfg = '{16'h0064, 16'hffce, 16'h0005};
	spps_pkg::spps_parw_t  par_w;
	spps_pkg::spps_val_t   mv_calc = '0, sp_upper = '0, sp_lower = '0, sp_wdata = '0;
	spps_pkg::spps_val_t   scale_hi = 16'h03e8, scale_lo = 16'hff9c, process_value = 16'h000a;
	spps_pkg::spps_val_t   manipulated_variable, present_setpoint, sp_hi_out, sp_lo_out, held_sp;
	int                    miscompares, n_tests, cycles, n;
	spps_top #(.TICK_CYCLES(TCK)) dut_u (.mclk, .rstn, .mode, .mv_cfg, .mv_calc, .lim_we, .sp_upper,
		.sp_lower, .range_change, .scale_hi, .scale_lo, .sp_we, .sp_wdata, .par_w, .rate_mode,
		.step_count, .process_value, .input_error, .run_cmd, .reset_cmd, .hold_set, .advance_set,
		.run_all_en, .power_continue, .restore_cmd, .restore_pat, .manipulated_variable,
		.present_setpoint, .sp_hi_out, .sp_lo_out, .step_no, .pattern_no, .repeat_no, .hold_led,
		.advance_clear, .running, .prog_end);
	spps_host host_u (.mclk, .par_w);
	// ------------------------------------------------------------
	// Clock, hang guard and shared tasks
	// ------------------------------------------------------------
	initial
	begin
		mclk = 1'h0;
		forever #10 mclk = ~mclk;
	end
	// Whole run needs roughly a thousand cycles; far above that means a hang
	always @(posedge mclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			miscompares++;
			final_report();
		end
	end
	// Inputs always change 1 ns after the edge, away from sampling
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : cyc
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic pulse_run;
		run_cmd = 1'h1;
		cyc(1);
		run_cmd = 1'h0;
	endtask : pulse_run
	task automatic pulse_reset;
		reset_cmd = 1'h1;
		cyc(1);
		reset_cmd = 1'h0;
	endtask : pulse_reset
	task automatic final_report;
		if (miscompares == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_mv_limits;
		mode.auto_tuning = 1'h1;
		mv_calc = 16'h00c8;
		cyc(2);
		chk("mv_heat", 16'h0064, manipulated_variable);
		mv_calc = 16'hfed4;
		cyc(2);
		chk("mv_cool", 16'hffce, manipulated_variable);
		mode.pos_prop = 1'h1;
		cyc(2);
		chk("mv_pospro", 16'hfed4, manipulated_variable);
		mode = '0;
		mode.manual = 1'h1;
		mv_calc = 16'h0000;
		cyc(2);
		chk("mv_manual", 16'h0000, manipulated_variable);
	endtask : t_mv_limits
	// Slew from 0 to 40 at 5 per second needs eight ticks
	task automatic t_mv_slew;
		mode = '0;
		mv_calc = 16'h0028;
		cyc(2 * TCK);
		chk("mv_slewing", 16'h0001, {15'h0, manipulated_variable <= 16'sh000f});
		cyc(8 * TCK + 2);
		chk("mv_reached", 16'h0028, manipulated_variable);
	endtask : t_mv_slew
	// Limits reset to zero, so open them to the scale before storing a setpoint
	task automatic t_sp_limits;
		range_change = 1'h1;
		cyc(1);
		range_change = 1'h0;
		sp_we = 1'h1;
		sp_wdata = 16'h0190;
		cyc(1);
		sp_we = 1'h0;
		sp_upper = 16'h012c;
		lim_we = 1'h1;
		cyc(1);
		lim_we = 1'h0;
		cyc(2);
		chk("sp_hi", 16'h012c, sp_hi_out);
		chk("sp_forced", 16'h012c, present_setpoint);
		range_change = 1'h1;
		lim_we = 1'h1;
		cyc(1);
		range_change = 1'h0;
		lim_we = 1'h0;
		cyc(1);
		chk("scale_hi", 16'h03e8, sp_hi_out);
		chk("scale_lo", 16'hff9c, sp_lo_out);
	endtask : t_sp_limits
	// Ramp 10 to 13 at 1 per minute, soak 3 s, pattern run twice
	task automatic t_ramp;
		pulse_run();
		process_value = 16'h0050;
		cyc(2);
		chk("run_step", 16'h0000, step_no);
		chk("run_rep", 16'h0001, repeat_no);
		chk("start_sp", 16'h000a, present_setpoint);
		process_value = 16'h000c;
		for (n = 0; n < 500 && step_no !== 4'h1; n++) cyc(1);
		chk("ramp_len", 16'h0001, {15'h0, n > 300});
		cyc(2);
		chk("ramp_sp", 16'h000d, present_setpoint);
		for (n = 0; n < 20 && repeat_no !== 16'h0002; n++) cyc(1);
		chk("rep_two", 16'h0002, repeat_no);
		for (n = 0; n < 600 && prog_end !== 1'h1; n++) cyc(1);
		chk("end_pulse", 16'h0001, prog_end);
		cyc(1);
		chk("end_run", 16'h0000, running);
		chk("end_rep", 16'h0000, repeat_no);
	endtask : t_ramp
	task automatic t_hold_adv;
		step_count = 4'h4;
		process_value = 16'h000a;
		pulse_run();
		cyc(2);
		hold_set = 1'h1;
		cyc(2);
		chk("hold_on", 16'h0001, hold_led);
		held_sp = present_setpoint;
		cyc(400);
		chk("hold_step", 16'h0000, step_no);
		chk("hold_sp", held_sp, present_setpoint);
		advance_set = 1'h1;
		cyc(1);
		advance_set = 1'h0;
		chk("adv_step", 16'h0001, step_no);
		chk("adv_clear", 16'h0001, advance_clear);
		chk("adv_hold", 16'h0001, hold_led);
		hold_set = 1'h0;
		cyc(2);
		chk("hold_off", 16'h0000, hold_led);
		for (n = 0; n < 20 && step_no !== 4'h2; n++) cyc(1);
		chk("soak_end", 16'h0002, step_no);
		hold_set = 1'h1;
		cyc(2);
		pulse_reset();
		cyc(1);
		chk("rst_hold", 16'h0000, hold_led);
		chk("rst_run", 16'h0000, running);
		chk("rst_rep", 16'h0000, repeat_no);
		hold_set = 1'h0;
	endtask : t_hold_adv
	task automatic t_err_zero;
		input_error = 1'h1;
		pulse_run();
		chk("err_step", 16'h0001, step_no);
		input_error = 1'h0;
		pulse_reset();
		host_u.write_elem(2'h0, 3'h0, spps_pkg::SEL_EXEC, 16'h0000);
		pulse_run();
		cyc(1);
		chk("zero_run", 16'h0000, running);
	endtask : t_err_zero
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		rstn = 1'h0;
		cyc(20);
		rstn = 1'h1;
		t_mv_limits();
		t_mv_slew();
		t_sp_limits();
		host_u.write_elem(2'h0, 3'h0, spps_pkg::SEL_TARGET, 16'h000d);
		host_u.write_elem(2'h0, 3'h0, spps_pkg::SEL_RATE, 16'h0001);
		host_u.write_elem(2'h0, 3'h0, spps_pkg::SEL_SOAK, 16'h0003);
		host_u.write_elem(2'h0, 3'h1, spps_pkg::SEL_TARGET, 16'h0014);
		host_u.write_elem(2'h0, 3'h1, spps_pkg::SEL_RATE, 16'h0001);
		host_u.write_elem(2'h0, 3'h1, spps_pkg::SEL_SOAK, 16'h0003);
		host_u.write_elem(2'h0, 3'h0, spps_pkg::SEL_EXEC, 16'h0002);
		t_ramp();
		host_u.write_elem(2'h0, 3'h0, spps_pkg::SEL_EXEC, 16'h0001);
		t_hold_adv();
		t_err_zero();
		final_report();
	end
endmodule : test_setpoint_program_sequencer
bind spps_top spps_checker chk_u (.mclk, .rstn, .mode, .mv_cfg, .mv_calc, .range_change, .scale_hi,
	.scale_lo, .rate_mode, .process_value, .input_error, .run_cmd, .reset_cmd, .hold_set,
	.advance_set, .manipulated_variable, .present_setpoint, .sp_hi_out, .sp_lo_out, .step_no,
	.repeat_no, .hold_led, .advance_clear, .running);
`default_nettype wire
